// >>> pkg/pas_pkg.sv
// constants, register map and carrier types of the protection/alarm sequencer
// assumes a 250 MHz clock and measurements coded as 0.1 V and whole degrees C
package pas_pkg;
  localparam int unsigned CLK_PERIOD_NS = 4;
  // common 10 ms time base
  localparam int unsigned TICK_MS = 10;
  localparam int unsigned TICK_CYCLES = (TICK_MS * 1000000) / CLK_PERIOD_NS;
  // persistence filters, in ms, rounded to whole ticks
  localparam int unsigned UV_SET_MS = 80;
  localparam int unsigned UV_SET_TICKS = (UV_SET_MS + TICK_MS - 1) / TICK_MS;
  localparam int unsigned UV_CLR_MS = 500;
  localparam int unsigned UV_CLR_TICKS = (UV_CLR_MS + TICK_MS - 1) / TICK_MS;
  // "more than" filters need one tick beyond the figure
  localparam int unsigned OT_SET_MS = 1000;
  localparam int unsigned OT_SET_TICKS = OT_SET_MS / TICK_MS + 1;
  localparam int unsigned OT_CLR_MS = 5000;
  localparam int unsigned OT_CLR_TICKS = OT_CLR_MS / TICK_MS + 1;
  localparam int unsigned AV_HOLD_MS = 15000;
  localparam int unsigned AV_HOLD_TICKS = (AV_HOLD_MS + TICK_MS - 1) / TICK_MS;
  localparam int unsigned DISP_ALT_MS = 500;
  localparam int unsigned DISP_ALT_TICKS = DISP_ALT_MS / TICK_MS;
  // delay step 0.1 s
  localparam int unsigned STEP_MS = 100;
  localparam int unsigned STEP_TICKS = STEP_MS / TICK_MS;
  // run time counts 0.1 kh = 360000 s
  localparam int unsigned RUN_UNIT_S = 360000;
  localparam int unsigned RUN_UNIT_TICKS = RUN_UNIT_S * (1000 / TICK_MS);
  // voltage in 0.1 V, temperature in degrees C
  localparam logic [9:0] UV_MIN = 10'h0B4;
  localparam logic [9:0] UV_MAX = 10'h108;
  localparam logic [9:0] UV_DEF = 10'h0C8;
  localparam logic [9:0] UV_HYST = 10'h003;
  localparam logic [9:0] AV_TRIP = 10'h120;
  localparam logic [9:0] AV_RESTORE = 10'h11D;
  localparam logic [7:0] OT_MIN = 8'h19;
  localparam logic [7:0] OT_MAX = 8'h50;
  localparam logic [7:0] OT_DEF = 8'h50;
  localparam logic [7:0] OT_HYST = 8'h03;
  localparam logic [9:0] VAL_MAX = 10'h3E7;
  localparam int unsigned NBR = 4;
  // error codes shown on the display
  localparam logic [11:0] CODE_AV = 12'hA10;
  localparam logic [11:0] CODE_UV = 12'hA21;
  localparam logic [11:0] CODE_RT = 12'hA23;
  localparam logic [11:0] CODE_OT = 12'hA30;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_UV_THR = 8'h04;
  localparam logic [7:0] ADDR_OT_SET = 8'h08;
  localparam logic [7:0] ADDR_RT_THR = 8'h0C;
  localparam logic [7:0] ADDR_TRIP_EN = 8'h10;
  localparam logic [7:0] ADDR_ON_DLY0 = 8'h14;
  localparam logic [7:0] ADDR_OFF_DLY0 = 8'h24;
  localparam logic [7:0] ADDR_STATUS = 8'h34;
  localparam logic [7:0] ADDR_RUNTIME = 8'h38;
  // control register bits, each a one-shot command
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_STOP = 1;
  localparam int unsigned CTRL_TEST_ON = 2;
  localparam int unsigned CTRL_TEST_OFF = 3;
  localparam int unsigned CTRL_TOOL_ON = 4;
  localparam int unsigned CTRL_TOOL_OFF = 5;
  localparam int unsigned CTRL_RECONNECT = 6;
  localparam int unsigned CTRL_RT_CLEAR = 7;
  // status register bits
  localparam int unsigned ST_UV = 0;
  localparam int unsigned ST_OT = 1;
  localparam int unsigned ST_RT = 2;
  localparam int unsigned ST_AV = 3;
  localparam int unsigned ST_LOCK = 4;
  localparam int unsigned ST_BR = 8;
  localparam int unsigned ST_WAIT = 12;

  typedef enum logic [1:0] {BR_OFF, BR_WAIT_ON, BR_ON, BR_WAIT_OFF} pas_br_e;

  typedef struct packed {
    logic err;
    logic show_code;
    logic [11:0] code;
    logic [9:0] value;
  } pas_disp_s;
endpackage : pas_pkg

// >>> hdl/pas_sequencer.sv
// alarm supervision and branch connect/disconnect sequencing
// assumes voltage/temperature words come from same-clock logic; power and trip are pins
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/100ps

module pas_sequencer #(
  parameter int unsigned TICK_CYCLES = pas_pkg::TICK_CYCLES,
  parameter int unsigned RUN_UNIT_TICKS = pas_pkg::RUN_UNIT_TICKS
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [9:0] i_volt,
  input wire logic [7:0] i_temp,
  input wire logic i_diag_done,
  input wire logic i_power_good,
  input wire logic i_trip,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  output logic o_fault_alarm_output,
  output logic o_overheat_output,
  output logic o_trip_alarm_output,
  output logic [3:0] o_branch_on,
  output logic [3:0] o_flash_green,
  output pas_pkg::pas_disp_s o_disp
);
  localparam int unsigned NBR = pas_pkg::NBR;

  function automatic logic [9:0] clamp10(input logic [9:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
    clamp10 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp10

  function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi);
    clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp8

  // pins pass two flops
  logic [1:0] pg_sync_reg;
  logic [1:0] trip_sync_reg;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pg_sync_reg <= 2'h0;
      trip_sync_reg <= 2'h0;
    end else begin
      pg_sync_reg <= {pg_sync_reg[0], i_power_good};
      trip_sync_reg <= {trip_sync_reg[0], i_trip};
    end
  end
  wire power_ok = pg_sync_reg[1];
  logic trip_d_reg;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) trip_d_reg <= 1'b0;
    else trip_d_reg <= trip_sync_reg[1];
  end
  wire trip_rise = trip_sync_reg[1] & ~trip_d_reg;

  logic [31:0] div_reg;
  logic tick;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= 32'h0;
      tick <= 1'b0;
    end else begin
      tick <= (div_reg == 32'(TICK_CYCLES - 1));
      div_reg <= (div_reg == 32'(TICK_CYCLES - 1)) ? 32'h0 : div_reg + 32'h1;
    end
  end

  // registers
  logic [9:0] uv_thr_reg;
  logic [7:0] ot_set_reg;
  logic [9:0] rt_thr_reg;
  logic [3:0] trip_en_reg;
  logic [9:0] on_dly_reg [NBR];
  logic [9:0] off_dly_reg [NBR];
  logic [7:0] cmd_reg;
  wire wr_ctrl = i_wr && i_addr == pas_pkg::ADDR_CTRL;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      uv_thr_reg <= pas_pkg::UV_DEF;
      ot_set_reg <= pas_pkg::OT_DEF;
      rt_thr_reg <= 10'h000;
      trip_en_reg <= 4'h0;
      cmd_reg <= 8'h00;
    end else begin
      cmd_reg <= wr_ctrl ? i_wdata[7:0] : 8'h00;
      if (i_wr) begin
        case (i_addr)
          pas_pkg::ADDR_UV_THR: uv_thr_reg <= clamp10(i_wdata[9:0], pas_pkg::UV_MIN,
                                                      pas_pkg::UV_MAX);
          pas_pkg::ADDR_OT_SET: ot_set_reg <= clamp8(i_wdata[7:0], pas_pkg::OT_MIN,
                                                     pas_pkg::OT_MAX);
          pas_pkg::ADDR_RT_THR: rt_thr_reg <= clamp10(i_wdata[9:0], 10'h000,
                                                      pas_pkg::VAL_MAX);
          pas_pkg::ADDR_TRIP_EN: trip_en_reg <= i_wdata[3:0];
          default: ;
        endcase
      end
    end
  end

  for (genvar g = 0; g < NBR; g++) begin : g_dly
    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        on_dly_reg[g] <= 10'h000;
        off_dly_reg[g] <= 10'h000;
      end else if (i_wr) begin
        if (i_addr == pas_pkg::ADDR_ON_DLY0 + 8'(4 * g))
          on_dly_reg[g] <= clamp10(i_wdata[9:0], 10'h000, pas_pkg::VAL_MAX);
        if (i_addr == pas_pkg::ADDR_OFF_DLY0 + 8'(4 * g))
          off_dly_reg[g] <= clamp10(i_wdata[9:0], 10'h000, pas_pkg::VAL_MAX);
      end
    end
  end

  logic uv_alarm_reg;
  logic [10:0] uv_cnt_reg;
  wire uv_low = i_volt < uv_thr_reg;
  wire uv_high = i_volt >= uv_thr_reg + pas_pkg::UV_HYST;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      uv_alarm_reg <= 1'b0;
      uv_cnt_reg <= 11'h000;
    end else if (!uv_alarm_reg) begin
      if (!uv_low) uv_cnt_reg <= 11'h000;
      else if (tick && uv_cnt_reg == 11'(pas_pkg::UV_SET_TICKS - 1)) begin
        uv_alarm_reg <= 1'b1;
        uv_cnt_reg <= 11'h000;
      end else if (tick) uv_cnt_reg <= uv_cnt_reg + 11'h001;
    end else begin
      if (!uv_high) uv_cnt_reg <= 11'h000;
      else if (tick && uv_cnt_reg == 11'(pas_pkg::UV_CLR_TICKS - 1)) begin
        uv_alarm_reg <= 1'b0;
        uv_cnt_reg <= 11'h000;
      end else if (tick) uv_cnt_reg <= uv_cnt_reg + 11'h001;
    end
  end

  logic ot_alarm_reg;
  logic [10:0] ot_cnt_reg;
  wire ot_hot = i_temp > ot_set_reg;
  wire ot_cool = i_temp <= ot_set_reg - pas_pkg::OT_HYST;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ot_alarm_reg <= 1'b0;
      ot_cnt_reg <= 11'h000;
    end else if (!ot_alarm_reg) begin
      if (!ot_hot) ot_cnt_reg <= 11'h000;
      else if (tick && ot_cnt_reg == 11'(pas_pkg::OT_SET_TICKS - 1)) begin
        ot_alarm_reg <= 1'b1;
        ot_cnt_reg <= 11'h000;
      end else if (tick) ot_cnt_reg <= ot_cnt_reg + 11'h001;
    end else begin
      if (!ot_cool) ot_cnt_reg <= 11'h000;
      else if (tick && ot_cnt_reg == 11'(pas_pkg::OT_CLR_TICKS - 1)) begin
        ot_alarm_reg <= 1'b0;
        ot_cnt_reg <= 11'h000;
      end else if (tick) ot_cnt_reg <= ot_cnt_reg + 11'h001;
    end
  end

  // run time in 0.1 kh, counted while powered, saturating
  logic [9:0] runtime_reg;
  logic [31:0] rt_pre_reg;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      runtime_reg <= 10'h000;
      rt_pre_reg <= 32'h0;
    end else if (cmd_reg[pas_pkg::CTRL_RT_CLEAR]) begin
      runtime_reg <= 10'h000;
      rt_pre_reg <= 32'h0;
    end else if (tick && power_ok) begin
      if (rt_pre_reg == 32'(RUN_UNIT_TICKS - 1)) begin
        rt_pre_reg <= 32'h0;
        if (runtime_reg != pas_pkg::VAL_MAX) runtime_reg <= runtime_reg + 10'h001;
      end else rt_pre_reg <= rt_pre_reg + 32'h1;
    end
  end

  logic rt_alarm_reg;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) rt_alarm_reg <= 1'b0;
    else if (rt_thr_reg != 10'h000 && runtime_reg > rt_thr_reg) rt_alarm_reg <= 1'b1;
    else if (rt_thr_reg == 10'h000 || rt_thr_reg > runtime_reg) rt_alarm_reg <= 1'b0;
  end

  logic av_trip_reg;
  logic [10:0] av_cnt_reg;
  wire av_over = i_volt >= pas_pkg::AV_TRIP;
  wire av_done = av_cnt_reg == 11'(pas_pkg::AV_HOLD_TICKS);
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      av_trip_reg <= 1'b0;
      av_cnt_reg <= 11'h000;
    end else if (av_over) begin
      av_trip_reg <= 1'b1;
      av_cnt_reg <= 11'h000;
    end else if (av_trip_reg) begin
      if (tick && !av_done) av_cnt_reg <= av_cnt_reg + 11'h001;
      if (av_done && i_volt < pas_pkg::AV_RESTORE) av_trip_reg <= 1'b0;
    end
  end

  // power-up start once self test finished
  logic pwr_armed_reg;
  logic pwr_start;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pwr_armed_reg <= 1'b1;
      pwr_start <= 1'b0;
    end else begin
      pwr_start <= pwr_armed_reg && power_ok && i_diag_done;
      if (!power_ok) pwr_armed_reg <= 1'b1;
      else if (i_diag_done) pwr_armed_reg <= 1'b0;
    end
  end

  wire start_req = pwr_start | cmd_reg[pas_pkg::CTRL_START] | cmd_reg[pas_pkg::CTRL_TEST_ON]
                   | cmd_reg[pas_pkg::CTRL_TOOL_ON] | cmd_reg[pas_pkg::CTRL_RECONNECT];
  wire stop_req = trip_rise | cmd_reg[pas_pkg::CTRL_STOP] | cmd_reg[pas_pkg::CTRL_TEST_OFF]
                  | cmd_reg[pas_pkg::CTRL_TOOL_OFF];
  wire kill_all = !power_ok || av_trip_reg;

  // 0.1 s step enable
  logic [3:0] step_cnt_reg;
  logic step;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      step_cnt_reg <= 4'h0;
      step <= 1'b0;
    end else begin
      step <= tick && step_cnt_reg == 4'(pas_pkg::STEP_TICKS - 1);
      if (tick) step_cnt_reg <= (step_cnt_reg == 4'(pas_pkg::STEP_TICKS - 1)) ? 4'h0
                                : step_cnt_reg + 4'h1;
    end
  end

  pas_pkg::pas_br_e br_st [NBR];
  logic [9:0] br_cnt_reg [NBR];
  for (genvar g = 0; g < NBR; g++) begin : g_br
    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        br_st[g] <= pas_pkg::BR_OFF;
        br_cnt_reg[g] <= 10'h000;
      end else if (kill_all) begin
        br_st[g] <= pas_pkg::BR_OFF;
        br_cnt_reg[g] <= 10'h000;
      end else begin
        case (br_st[g])
          pas_pkg::BR_OFF: begin
            br_cnt_reg[g] <= 10'h000;
            if (start_req)
              br_st[g] <= (on_dly_reg[g] == 10'h000) ? pas_pkg::BR_ON : pas_pkg::BR_WAIT_ON;
          end
          pas_pkg::BR_WAIT_ON: begin
            // only trip-enabled branches take the shutdown
            if (stop_req && trip_en_reg[g]) begin
              br_cnt_reg[g] <= 10'h000;
              br_st[g] <= (off_dly_reg[g] == 10'h000) ? pas_pkg::BR_OFF : pas_pkg::BR_WAIT_OFF;
            end else if (br_cnt_reg[g] >= on_dly_reg[g]) begin
              br_st[g] <= pas_pkg::BR_ON;
            end else if (step) begin
              br_cnt_reg[g] <= br_cnt_reg[g] + 10'h001;
            end
          end
          pas_pkg::BR_ON: begin
            br_cnt_reg[g] <= 10'h000;
            if (stop_req && trip_en_reg[g])
              br_st[g] <= (off_dly_reg[g] == 10'h000) ? pas_pkg::BR_OFF : pas_pkg::BR_WAIT_OFF;
          end
          pas_pkg::BR_WAIT_OFF: begin
            if (br_cnt_reg[g] >= off_dly_reg[g]) br_st[g] <= pas_pkg::BR_OFF;
            else if (step) br_cnt_reg[g] <= br_cnt_reg[g] + 10'h001;
          end
          default: br_st[g] <= pas_pkg::BR_OFF;
        endcase
      end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
        o_branch_on[g] <= 1'b0;
        o_flash_green[g] <= 1'b0;
      end else begin
        o_branch_on[g] <= !kill_all && (br_st[g] == pas_pkg::BR_ON
                                        || br_st[g] == pas_pkg::BR_WAIT_OFF);
        o_flash_green[g] <= !kill_all && br_st[g] == pas_pkg::BR_WAIT_ON;
      end
    end
  end

  // alarm outputs are high while healthy
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fault_alarm_output <= 1'b1;
      o_overheat_output <= 1'b1;
      o_trip_alarm_output <= 1'b1;
    end else begin
      o_fault_alarm_output <= !(uv_alarm_reg || rt_alarm_reg);
      o_overheat_output <= !ot_alarm_reg;
      o_trip_alarm_output <= !av_trip_reg;
    end
  end

  // display alternates code and value each half second
  logic [5:0] alt_cnt_reg;
  logic alt_reg;
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      alt_cnt_reg <= 6'h00;
      alt_reg <= 1'b1;
    end else if (tick) begin
      if (alt_cnt_reg == 6'(pas_pkg::DISP_ALT_TICKS - 1)) begin
        alt_cnt_reg <= 6'h00;
        alt_reg <= ~alt_reg;
      end else alt_cnt_reg <= alt_cnt_reg + 6'h01;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_disp <= '0;
    end else begin
      o_disp.err <= av_trip_reg | uv_alarm_reg | rt_alarm_reg | ot_alarm_reg;
      o_disp.show_code <= alt_reg && (av_trip_reg | uv_alarm_reg | rt_alarm_reg
                                      | ot_alarm_reg);
      if (av_trip_reg) begin
        o_disp.code <= pas_pkg::CODE_AV;
        o_disp.value <= i_volt;
      end else if (uv_alarm_reg) begin
        o_disp.code <= pas_pkg::CODE_UV;
        o_disp.value <= i_volt;
      end else if (rt_alarm_reg) begin
        o_disp.code <= pas_pkg::CODE_RT;
        o_disp.value <= runtime_reg;
      end else if (ot_alarm_reg) begin
        o_disp.code <= pas_pkg::CODE_OT;
        o_disp.value <= {2'h0, i_temp};
      end else begin
        o_disp.code <= 12'h000;
        o_disp.value <= i_volt;
      end
    end
  end

  // read port, data one cycle after the strobe only
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    case (i_addr)
      pas_pkg::ADDR_UV_THR: rd_mux = {22'h0, uv_thr_reg};
      pas_pkg::ADDR_OT_SET: rd_mux = {24'h0, ot_set_reg};
      pas_pkg::ADDR_RT_THR: rd_mux = {22'h0, rt_thr_reg};
      pas_pkg::ADDR_TRIP_EN: rd_mux = {28'h0, trip_en_reg};
      pas_pkg::ADDR_RUNTIME: rd_mux = {22'h0, runtime_reg};
      pas_pkg::ADDR_STATUS: begin
        rd_mux[pas_pkg::ST_UV] = uv_alarm_reg;
        rd_mux[pas_pkg::ST_OT] = ot_alarm_reg;
        rd_mux[pas_pkg::ST_RT] = rt_alarm_reg;
        rd_mux[pas_pkg::ST_AV] = av_trip_reg;
        rd_mux[pas_pkg::ST_LOCK] = av_trip_reg && !av_done;
        rd_mux[pas_pkg::ST_BR +: 4] = o_branch_on;
        rd_mux[pas_pkg::ST_WAIT +: 4] = o_flash_green;
      end
      default: begin
        for (int k = 0; k < NBR; k++) begin
          if (i_addr == pas_pkg::ADDR_ON_DLY0 + 8'(4 * k)) rd_mux = {22'h0, on_dly_reg[k]};
          if (i_addr == pas_pkg::ADDR_OFF_DLY0 + 8'(4 * k)) rd_mux = {22'h0, off_dly_reg[k]};
        end
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) o_rdata <= 32'h0;
    else o_rdata <= i_rd ? rd_mux : 32'h0;
  end
endmodule : pas_sequencer

// >>> bench/pas_seq_chk.sv
// port-level assertions for the alarm sequencer
// assumes default uv threshold and temperature set value stay in force
`timescale 1ns/100ps
module pas_seq_chk #(
  parameter int unsigned TICK_CYCLES = 10,
  parameter int unsigned RUN_UNIT_TICKS = 3
) (
  input wire logic i_clock,
  input wire logic i_rst_n,
  input wire logic [9:0] i_volt,
  input wire logic [7:0] i_temp,
  input wire logic i_power_good,
  input wire logic o_fault_alarm_output,
  input wire logic o_overheat_output,
  input wire logic o_trip_alarm_output,
  input wire logic [3:0] o_branch_on,
  input wire logic [3:0] o_flash_green,
  input wire pas_pkg::pas_disp_s o_disp
);
  // cycles each input condition has held, saturating
  logic [15:0] hot_reg, cool_reg, low_reg, ok_reg, av_reg;
  function automatic logic [15:0] sat(input logic c, input logic [15:0] n);
    return c ? ((n == 16'hFFFF) ? n : n + 16'h0001) : 16'h0000;
  endfunction : sat
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hot_reg <= 16'h0000;
      cool_reg <= 16'h0000;
      low_reg <= 16'h0000;
      ok_reg <= 16'h0000;
      av_reg <= 16'hFFFF;
    end else begin
      hot_reg <= sat(i_temp > pas_pkg::OT_DEF, hot_reg);
      cool_reg <= sat(i_temp <= pas_pkg::OT_DEF - pas_pkg::OT_HYST, cool_reg);
      low_reg <= sat(i_volt < pas_pkg::UV_DEF, low_reg);
      ok_reg <= sat(i_volt >= pas_pkg::UV_DEF + pas_pkg::UV_HYST, ok_reg);
      av_reg <= sat(i_volt < pas_pkg::AV_TRIP, av_reg);
    end
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  uv_set_a: assert property (low_reg == 10 * TICK_CYCLES + 3 |-> !o_fault_alarm_output)
    else $error("fault alarm missed undervoltage");
  uv_code_a: assert property (low_reg >= 12 * TICK_CYCLES && o_disp.show_code
    |-> o_disp.code == pas_pkg::CODE_UV) else $error("wrong undervoltage code");
  uv_clear_a: assert property ($rose(o_fault_alarm_output) |-> ok_reg >= 49 * TICK_CYCLES)
    else $error("fault alarm cleared too early");
  ot_set_a: assert property ($fell(o_overheat_output) |-> hot_reg >= 100 * TICK_CYCLES)
    else $error("overheat dropped too early");
  ot_clear_a: assert property ($rose(o_overheat_output) |-> cool_reg >= 500 * TICK_CYCLES)
    else $error("overheat restored too early");
  ot_err_a: assert property (!o_overheat_output |-> o_disp.err)
    else $error("overheat off without error");
  av_cut_a: assert property (i_volt >= pas_pkg::AV_TRIP
    |-> ##[1:3] (o_branch_on == 4'h0 && !o_trip_alarm_output)) else $error("no abnormal cut");
  av_hold_a: assert property ($rose(o_trip_alarm_output) |-> av_reg >= 1499 * TICK_CYCLES
    && $past(i_volt) < pas_pkg::AV_RESTORE) else $error("trip released too early");
  pwr_cut_a: assert property (!i_power_good |-> ##[1:5] o_branch_on == 4'h0)
    else $error("branches kept on without power");
  flash_off_a: assert property ((o_flash_green & o_branch_on) == 4'h0)
    else $error("flashing on a connected branch");
  cover property ($fell(o_fault_alarm_output));
  cover property ($fell(o_overheat_output));
  cover property ($fell(o_trip_alarm_output));
  cover property (o_flash_green != 4'h0);
endmodule : pas_seq_chk

bind pas_sequencer pas_seq_chk #(.TICK_CYCLES(TICK_CYCLES), .RUN_UNIT_TICKS(RUN_UNIT_TICKS))
  u_chk (.i_clock, .i_rst_n, .i_volt, .i_temp, .i_power_good, .o_fault_alarm_output,
  .o_overheat_output, .o_trip_alarm_output, .o_branch_on, .o_flash_green, .o_disp);

// >>> bench/pas_relay_model.sv
// fan relay, alarm lamp and branch loads behind the sequencer
// assumes the fan relay is fed through a short time-delay stage
`timescale 1ns/100ps
module pas_relay_model (
  input wire logic i_clock,
  input wire logic i_overheat_output,
  input wire logic i_fault_alarm_output,
  input wire logic [3:0] i_branch_on,
  output logic o_fan_on,
  output logic o_alarm_lamp,
  output logic [2:0] o_loads_on
);
  logic [1:0] fan_reg = 2'h0;
  // delay stage hides the momentary blip at power-on
  always_ff @(posedge i_clock) begin
    fan_reg <= {fan_reg[0], !i_overheat_output};
  end
  assign o_fan_on = fan_reg[1] & fan_reg[0];
  assign o_alarm_lamp = !i_fault_alarm_output;
  assign o_loads_on = 3'($countones(i_branch_on));
endmodule : pas_relay_model

// >>> bench/testbench.sv
// self-checking bench for the alarm sequencer
// assumes a 10-cycle tick and a 3-tick run-time unit
`timescale 1ns/100ps
module testbench;
  localparam int unsigned TK = 10;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic [9:0] i_volt = 10'h0F0;
  logic [7:0] i_temp = 8'h28;
  logic i_diag_done = 1'b0;
  logic i_power_good = 1'b1;
  logic i_trip = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic o_fault_alarm_output, o_overheat_output, o_trip_alarm_output;
  logic [3:0] o_branch_on, o_flash_green, wmask;
  pas_pkg::pas_disp_s o_disp;
  logic fan_on, alarm_lamp;
  logic [2:0] loads_on;
  logic [31:0] rv;
  int miscompares = 0;
  int comparisons = 0;
  int seed = 32'hA9B1F5B4;
  always #2 i_clock = ~i_clock;
  pas_sequencer #(.TICK_CYCLES(TK), .RUN_UNIT_TICKS(3)) u_dut (.i_clock, .i_rst_n, .i_volt,
    .i_temp, .i_diag_done, .i_power_good, .i_trip, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .o_fault_alarm_output, .o_overheat_output, .o_trip_alarm_output, .o_branch_on,
    .o_flash_green, .o_disp);
  pas_relay_model u_far (.i_clock, .i_overheat_output(o_overheat_output),
    .i_fault_alarm_output(o_fault_alarm_output), .i_branch_on(o_branch_on),
    .o_fan_on(fan_on), .o_alarm_lamp(alarm_lamp), .o_loads_on(loads_on));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask : cyc
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    cyc(1);
    i_wr <= 1'b0;
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    cyc(1);
    i_rd <= 1'b0;
    // read data stand one cycle only, so look mid-cycle
    @(negedge i_clock);
    chk("rdata", e, o_rdata);
    cyc(1);
  endtask : rd
  // code phase then value phase of the alternating display
  task automatic disp(input logic [11:0] c, input logic [9:0] v);
    int n;
    n = 0;
    while (o_disp.show_code !== 1'b1 && n < 1200) begin
      cyc(1);
      n++;
    end
    chk("code", c, o_disp.code);
    while (o_disp.show_code !== 1'b0 && n < 2400) begin
      cyc(1);
      n++;
    end
    chk("value", v, o_disp.value);
  endtask : disp
  function automatic logic [3:0] wait_mask(input logic [31:0] d);
    for (int b = 0; b < 4; b++) wait_mask[b] = |d[2*b +: 2];
  endfunction : wait_mask
  task automatic summarize();
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    cyc(60000);
    miscompares++;
    summarize();
  end
  initial begin
    cyc(2);
    i_rst_n <= 1'b1;
    cyc(20);
    chk("branch", 32'h0, o_branch_on);
    i_diag_done <= 1'b1;
    cyc(8);
    chk("branch", 32'hF, o_branch_on);
    rd(pas_pkg::ADDR_UV_THR, 32'hC8);
    rd(8'hFC, 32'h0);
    wr(pas_pkg::ADDR_TRIP_EN, 32'hF);
    for (int k = 0; k < 4; k++) begin
      if (k == 3) begin
        i_trip <= 1'b1;
        cyc(6);
        i_trip <= 1'b0;
      end else begin
        wr(pas_pkg::ADDR_CTRL, 32'h1 << (2 * k + 1));
      end
      cyc(4);
      chk("stop", 32'h0, o_branch_on);
      rv = $random(seed);
      for (int b = 0; b < 4; b++) begin
        wr(pas_pkg::ADDR_ON_DLY0 + 8'(4 * b), 32'(rv[2*b +: 2]));
        rd(pas_pkg::ADDR_ON_DLY0 + 8'(4 * b), 32'(rv[2*b +: 2]));
      end
      wmask = wait_mask(rv);
      wr(pas_pkg::ADDR_CTRL, 32'h1 << (2 * k));
      cyc(2);
      chk("flash", wmask, o_flash_green);
      chk("branch", wmask ^ 4'hF, o_branch_on);
      cyc(500);
      chk("loads", 32'h4, loads_on);
    end
    wr(pas_pkg::ADDR_TRIP_EN, 32'h5);
    wr(pas_pkg::ADDR_OFF_DLY0 + 8'h08, 32'h2);
    wr(pas_pkg::ADDR_CTRL, 32'h2);
    cyc(60);
    chk("delayed stop", 32'hE, o_branch_on);
    cyc(340);
    chk("delayed stop", 32'hA, o_branch_on);
    i_power_good <= 1'b0;
    cyc(6);
    chk("power loss", 32'h0, o_branch_on);
    i_power_good <= 1'b1;
    cyc(4);
    wr(pas_pkg::ADDR_CTRL, 32'h40);
    cyc(500);
    chk("reconnect", 32'hF, o_branch_on);
    i_volt <= 10'h0BE;
    cyc(12 * TK);
    chk("fault", 32'h0, o_fault_alarm_output);
    chk("lamp", 32'h1, alarm_lamp);
    disp(pas_pkg::CODE_UV, 10'h0BE);
    i_volt <= 10'h0CA;
    cyc(70 * TK);
    chk("fault", 32'h0, o_fault_alarm_output);
    i_volt <= 10'h0CB;
    cyc(55 * TK);
    chk("fault", 32'h1, o_fault_alarm_output);
    i_temp <= 8'h51;
    cyc(103 * TK);
    chk("overheat", 32'h0, o_overheat_output);
    chk("fault", 32'h1, o_fault_alarm_output);
    chk("fan", 32'h1, fan_on);
    disp(pas_pkg::CODE_OT, 10'h051);
    i_temp <= 8'h4E;
    cyc(510 * TK);
    chk("overheat", 32'h0, o_overheat_output);
    i_temp <= 8'h4D;
    cyc(503 * TK);
    chk("overheat", 32'h1, o_overheat_output);
    chk("err", 32'h0, o_disp.err);
    rd(pas_pkg::ADDR_RT_THR, 32'h0);
    chk("fault", 32'h1, o_fault_alarm_output);
    wr(pas_pkg::ADDR_CTRL, 32'h80);
    wr(pas_pkg::ADDR_RT_THR, 32'h2);
    cyc(150);
    rd(pas_pkg::ADDR_STATUS, 32'hF04);
    chk("fault", 32'h0, o_fault_alarm_output);
    wr(pas_pkg::ADDR_CTRL, 32'h80);
    cyc(3);
    chk("fault", 32'h1, o_fault_alarm_output);
    cyc(150);
    chk("fault", 32'h0, o_fault_alarm_output);
    wr(pas_pkg::ADDR_RT_THR, 32'h3E7);
    cyc(3);
    chk("fault", 32'h1, o_fault_alarm_output);
    wr(pas_pkg::ADDR_RT_THR, 32'h0);
    i_volt <= 10'h122;
    cyc(4);
    chk("trip", 32'h0, o_trip_alarm_output);
    chk("branch", 32'h0, o_branch_on);
    i_volt <= 10'h0F0;
    disp(pas_pkg::CODE_AV, 10'h0F0);
    cyc(1300 * TK);
    chk("trip", 32'h0, o_trip_alarm_output);
    cyc(210 * TK);
    chk("trip", 32'h1, o_trip_alarm_output);
    chk("branch", 32'h0, o_branch_on);
    wr(pas_pkg::ADDR_CTRL, 32'h40);
    cyc(500);
    chk("reconnect", 32'hF, o_branch_on);
    summarize();
  end
endmodule : testbench
